// ---- rtl/servo_pkg.sv ----
package servo_pkg;
   // data path widths
   localparam int CMD_W  = 16;                    // signed motion command width
   localparam int DIG_W  = 4;                     // one configuration digit
   localparam int SYN_W  = 7;                     // number of synchronised pins
   localparam int EVT_W  = 5;                     // number of interrupt events
   localparam int ADDR_W = 8;                     // decoded apb address bits

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CONFIG  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_COMMAND = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_INT_ST  = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_INT_MSK = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_ALM_RST = 8'h14;

   // configuration digit values
   localparam logic [DIG_W-1:0] SRC_INPUT = 4'h0;  // enable from servo-on pin
   localparam logic [DIG_W-1:0] SRC_PERM  = 4'h9;  // enable active whenever main power is ok
   localparam logic [DIG_W-1:0] ASG_FWD   = 4'h2;  // forward limit on its pin
   localparam logic [DIG_W-1:0] ASG_REV   = 4'h3;  // reverse limit on its pin
   localparam logic [DIG_W-1:0] ASG_OFF   = 4'h8;  // limit checking disabled

   // reset values
   localparam logic [SYN_W-1:0] SYN_INIT = 7'h07;  // servo-on pin and both limits idle high
   localparam logic [EVT_W-1:0] MSK_INIT = 5'h00;

   // event bit positions in interrupt status and mask
   localparam int EV_ON    = 0;                   // servo entered on state
   localparam int EV_OFF   = 1;                   // servo left on state
   localparam int EV_FWDOT = 2;                   // forward overtravel began
   localparam int EV_REVOT = 3;                   // reverse overtravel began
   localparam int EV_ALARM = 4;                   // alarm cut the drive

   // configuration register layout
   typedef struct packed {
      logic             zero_hold;                // stop_method_param hold bit
      logic             cw_forward;               // direction_param digit
      logic [DIG_W-1:0] rev_asg;                  // reverse limit assignment
      logic [DIG_W-1:0] fwd_asg;                  // forward limit assignment
      logic [DIG_W-1:0] son_src;                  // servo-on source digit
   } cfg_t;

   localparam cfg_t CFG_INIT = '{zero_hold: 1'b0, cw_forward: 1'b0,
                                 rev_asg: ASG_REV, fwd_asg: ASG_FWD, son_src: SRC_INPUT};

   // servo control states
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,                            // de-energized
      ST_ON  = 3'b010,                            // energized, drivable
      ST_ALM = 3'b100                             // cut by alarm, awaits reset
   } servo_st_t;
endpackage : servo_pkg

// ---- rtl/pin_sync.sv ----
`timescale 1ns/10ps
// two-stage synchroniser, one chain per pin
module pin_sync (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic [servo_pkg::SYN_W-1:0] din,
   output logic      [servo_pkg::SYN_W-1:0] dout
);
   import servo_pkg::*;

   logic [SYN_W-1:0] meta_r;                      // first stage, read by second only

   ////////////////////////////////////////////////////////////////////////////////
   // per-bit chain
   genvar g;
   generate
      for (g = 0; g < SYN_W; g++) begin : g_bit
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_r[g] <= SYN_INIT[g];
               dout[g]   <= SYN_INIT[g];
            end else begin
               meta_r[g] <= din[g];
               dout[g]   <= meta_r[g];
            end
         end
      end
   endgenerate
endmodule : pin_sync

// ---- rtl/quad_gen.sv ----
`timescale 1ns/10ps
// divided encoder pulse generator, one quadrature step per pulse
module quad_gen (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic step,                        // one-cycle step pulse
   input  wire logic fwd,                         // command polarity is forward
   output logic      divided_pulse_phase_a,
   output logic      divided_pulse_phase_b
);
   import servo_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // gray walk: forward lets b lead a, reverse lets a lead b
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         divided_pulse_phase_a <= 1'b0;
         divided_pulse_phase_b <= 1'b0;
      end else if (step) begin
         if (fwd ^ divided_pulse_phase_a ^ divided_pulse_phase_b) begin   // [RULE10] [RULE9]
            divided_pulse_phase_b <= ~divided_pulse_phase_b;
         end else begin
            divided_pulse_phase_a <= ~divided_pulse_phase_a;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   a_fwd_b_leads: assert property (@(posedge clk) disable iff (rst)   // [RULE10]
      (step && fwd && !divided_pulse_phase_a && !divided_pulse_phase_b)
      |=> (divided_pulse_phase_b && !divided_pulse_phase_a))
      else $error("forward step did not raise phase b first");
   a_rev_a_leads: assert property (@(posedge clk) disable iff (rst)   // [RULE10]
      (step && !fwd && !divided_pulse_phase_a && !divided_pulse_phase_b)
      |=> (divided_pulse_phase_a && !divided_pulse_phase_b))
      else $error("reverse step did not raise phase a first");
endmodule : quad_gen

// ---- rtl/servo_enable_and_travel_limit.sv ----
// The APB register port and the address map were decided locally.
`timescale 1ns/10ps
// Summary of operation
// RULE1 - servo-on request active energizes motor
// RULE2 - request inactive keeps motor de-energized
// RULE3 - source digit 0 uses pin, 9 permanent
// RULE4 - permanent mode energizes once main power present
// RULE5 - servo on granted only with motor stopped
// RULE6 - permanent mode recovers after alarm reset
// RULE7 - host commands only after servo on
// RULE8 - direction digit maps command to rotation
// RULE9 - direction digit leaves pulse phase unchanged
// RULE10 - forward command: b leads; reverse: a leads
// RULE11 - forward limit inactive forbids forward drive
// RULE12 - reverse limit inactive forbids reverse drive
// RULE13 - overtravel forces stop, overriding prohibited command
// RULE14 - after overtravel stop cut drive unless holding
// RULE15 - brake stays released during overtravel
// RULE16 - vertical axes should configure zero hold
// RULE17 - limit digit 8 disables that check
// RULE18 - sync inputs; ignore commands while de-energized
module servo_enable_and_travel_limit (
   input  wire logic                      CLOCK,
   input  wire logic                      RST,
   // apb slave
   input  wire logic                      PSEL,
   input  wire logic                      PENABLE,
   input  wire logic                      PWRITE,
   input  wire logic [servo_pkg::ADDR_W-1:0] PADDR,
   input  wire logic [31:0]               PWDATA,
   output logic      [31:0]               PRDATA,
   output logic                           PREADY,
   output logic                           PSLVERR,
   // pins from host, switches and power stage
   input  wire logic                      SERVO_ON_REQ_N,
   input  wire logic                      FORWARD_LIMIT_INPUT,
   input  wire logic                      REVERSE_LIMIT_INPUT,
   input  wire logic                      MAIN_POWER_OK,
   input  wire logic                      MOTOR_STOPPED,
   input  wire logic                      DRIVE_ALARM,
   input  wire logic                      ENCODER_STEP,
   // to power stage and host
   output logic                           MOTOR_ENERGIZE,
   output logic                           DRIVE_ENABLE,
   output logic                           ZERO_HOLD,
   output logic                           BRAKE_CONTROL_OUTPUT,
   output logic signed [servo_pkg::CMD_W-1:0] MOTOR_CMD,
   output logic                           MOTOR_CW,
   output logic                           DIVIDED_PULSE_PHASE_A,
   output logic                           DIVIDED_PULSE_PHASE_B,
   output logic                           INTERRUPT
);
   import servo_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   cfg_t                     cfg_r;              // configuration digits
   logic signed [CMD_W-1:0]  cmd_r;              // host motion command
   logic [EVT_W-1:0]         int_st_r;           // sticky events
   logic [EVT_W-1:0]         int_msk_r;          // event enables
   logic [EVT_W-1:0]         evt;                // event pulses this cycle
   servo_st_t                st_r;               // servo state
   servo_st_t                st_nxt;
   logic                     ot_stop_r;          // overtravel stop completed
   logic                     fwd_ot_r;           // delayed for edge detect
   logic                     rev_ot_r;
   logic                     step_r;             // encoder step edge detect
   logic [SYN_W-1:0]         pins;               // synchronised pins
   logic                     son_n, fwd_lim, rev_lim, pwr_ok, stopped, alarm, enc;
   logic                     son_req;            // effective servo-on request
   logic                     fwd_ot, rev_ot;     // overtravel levels
   logic                     wr, rd, mapped;     // apb decode
   logic                     alm_rst;            // alarm reset write pulse
   logic signed [CMD_W-1:0]  cmd_eff;            // command after gating
   logic [31:0]              rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   pin_sync u_sync (                                                     // [RULE18]
      .clk  (CLOCK),
      .rst  (RST),
      .din  ({ENCODER_STEP, DRIVE_ALARM, MOTOR_STOPPED, MAIN_POWER_OK,
              REVERSE_LIMIT_INPUT, FORWARD_LIMIT_INPUT, SERVO_ON_REQ_N}),
      .dout (pins)
   );
   assign {enc, alarm, stopped, pwr_ok, rev_lim, fwd_lim, son_n} = pins;

   ////////////////////////////////////////////////////////////////////////////////
   // apb decode, zero wait states
   assign wr      = PSEL && PENABLE && PWRITE;
   assign rd      = PSEL && PENABLE && !PWRITE;
   assign PREADY  = 1'b1;
   assign mapped  = (PADDR == OFS_CONFIG) || (PADDR == OFS_COMMAND) ||
                    (PADDR == OFS_STATUS) || (PADDR == OFS_INT_ST) ||
                    (PADDR == OFS_INT_MSK) || (PADDR == OFS_ALM_RST);
   assign PSLVERR = PSEL && PENABLE && !mapped;
   assign alm_rst = wr && (PADDR == OFS_ALM_RST) && PWDATA[0];

   // configuration and command registers
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cfg_r     <= CFG_INIT;
         cmd_r     <= '0;
         int_msk_r <= MSK_INIT;
      end else if (wr) begin
         if (PADDR == OFS_CONFIG)  cfg_r     <= cfg_t'(PWDATA[$bits(cfg_t)-1:0]);
         if (PADDR == OFS_COMMAND) cmd_r     <= PWDATA[CMD_W-1:0];
         if (PADDR == OFS_INT_MSK) int_msk_r <= PWDATA[EVT_W-1:0];
      end
   end

   // read mux
   always_comb begin
      rdata = '0;
      unique case (PADDR)
         OFS_CONFIG:  rdata[$bits(cfg_t)-1:0] = cfg_r;
         OFS_COMMAND: rdata[CMD_W-1:0]        = cmd_r;
         OFS_STATUS:  rdata[9:0] = {pins[6:1], ot_stop_r, st_r};
         OFS_INT_ST:  rdata[EVT_W-1:0]        = int_st_r;
         OFS_INT_MSK: rdata[EVT_W-1:0]        = int_msk_r;
         default:     rdata = '0;
      endcase
   end

   // read data register, loaded in setup phase
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         PRDATA <= '0;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         PRDATA <= rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // enable source and overtravel levels
   assign son_req = (cfg_r.son_src == SRC_PERM) ? pwr_ok : !son_n;       // [RULE3] [RULE4]
   assign fwd_ot  = (cfg_r.fwd_asg != ASG_OFF) && !fwd_lim;              // [RULE11] [RULE17]
   assign rev_ot  = (cfg_r.rev_asg != ASG_OFF) && !rev_lim;              // [RULE12] [RULE17]

   ////////////////////////////////////////////////////////////////////////////////
   // servo state machine
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ST_OFF: begin
            // grant only to a stopped motor with power
            if (son_req && stopped && pwr_ok && !alarm) st_nxt = ST_ON;  // [RULE1] [RULE5]
         end
         ST_ON: begin
            if (alarm)                     st_nxt = ST_ALM;
            else if (!son_req || !pwr_ok)  st_nxt = ST_OFF;              // [RULE2]
         end
         ST_ALM: begin
            // permanent mode re-enters on via off state
            if (alm_rst && !alarm)         st_nxt = ST_OFF;              // [RULE6]
         end
         default: st_nxt = ST_OFF;
      endcase
   end

   // state register
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) st_r <= ST_OFF;
      else     st_r <= st_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // overtravel stop tracking
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ot_stop_r <= 1'b0;
      end else if (!(fwd_ot || rev_ot) || st_r != ST_ON) begin
         ot_stop_r <= 1'b0;
      end else if (stopped) begin
         ot_stop_r <= 1'b1;                                              // [RULE14]
      end
   end

   // command gating: nothing while off, no drive into a limit
   always_comb begin
      cmd_eff = cmd_r;
      if (st_r != ST_ON)                     cmd_eff = '0;               // [RULE18] [RULE7]
      else if (fwd_ot && cmd_r > 0)          cmd_eff = '0;               // [RULE13]
      else if (rev_ot && cmd_r < 0)          cmd_eff = '0;               // [RULE13]
      else if (ot_stop_r && !cfg_r.zero_hold) cmd_eff = '0;              // [RULE14]
   end

   // power stage outputs
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         MOTOR_ENERGIZE       <= 1'b0;
         DRIVE_ENABLE         <= 1'b0;
         ZERO_HOLD            <= 1'b0;
         BRAKE_CONTROL_OUTPUT <= 1'b0;
         MOTOR_CMD            <= '0;
         MOTOR_CW             <= 1'b0;
      end else begin
         MOTOR_ENERGIZE       <= (st_r == ST_ON);                        // [RULE1] [RULE2]
         DRIVE_ENABLE         <= (st_r == ST_ON) && !(ot_stop_r && !cfg_r.zero_hold); // [RULE14]
         ZERO_HOLD            <= ot_stop_r && cfg_r.zero_hold;
         BRAKE_CONTROL_OUTPUT <= (st_r == ST_ON);                        // [RULE15]
         MOTOR_CMD            <= cmd_eff;
         // rotation sense only; command polarity untouched
         if (cmd_eff != 0) MOTOR_CW <= cmd_eff[CMD_W-1] ^ !cfg_r.cw_forward ^ 1'b1; // [RULE8]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // divided pulses follow command polarity only
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) step_r <= 1'b0;
      else     step_r <= enc;
   end

   quad_gen u_quad (
      .clk                   (CLOCK),
      .rst                   (RST),
      .step                  (enc && !step_r),
      .fwd                   (!MOTOR_CMD[CMD_W-1]),                      // [RULE9] [RULE10]
      .divided_pulse_phase_a (DIVIDED_PULSE_PHASE_A),
      .divided_pulse_phase_b (DIVIDED_PULSE_PHASE_B)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt events, set wins over write-one clear
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         fwd_ot_r <= 1'b0;
         rev_ot_r <= 1'b0;
      end else begin
         fwd_ot_r <= fwd_ot;
         rev_ot_r <= rev_ot;
      end
   end

   always_comb begin
      evt           = '0;
      evt[EV_ON]    = (st_r != ST_ON) && (st_nxt == ST_ON);
      evt[EV_OFF]   = (st_r == ST_ON) && (st_nxt != ST_ON);
      evt[EV_FWDOT] = fwd_ot && !fwd_ot_r;
      evt[EV_REVOT] = rev_ot && !rev_ot_r;
      evt[EV_ALARM] = (st_r != ST_ALM) && (st_nxt == ST_ALM);
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         int_st_r <= '0;
      end else if (wr && PADDR == OFS_INT_ST) begin
         int_st_r <= (int_st_r & ~PWDATA[EVT_W-1:0]) | evt;
      end else begin
         int_st_r <= int_st_r | evt;
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) INTERRUPT <= 1'b0;
      else     INTERRUPT <= |(int_st_r & int_msk_r);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   a_grant_on_req: assert property (                                     // [RULE1]
      (st_r == ST_OFF && son_req && stopped && pwr_ok && !alarm) |=> ##1 MOTOR_ENERGIZE)
      else $error("servo on request not granted");
   a_drop_on_off: assert property (                                      // [RULE2]
      (st_r == ST_ON && !son_req && !alarm) |=> ##1 !MOTOR_ENERGIZE)
      else $error("motor still energized without request");
   a_perm_source: assert property (                                      // [RULE3] [RULE4]
      (cfg_r.son_src == SRC_PERM && st_r == ST_OFF && pwr_ok && stopped && !alarm)
      |=> st_r == ST_ON)
      else $error("permanent source did not energize with main power");
   a_moving_refused: assert property (                                   // [RULE5]
      (st_r == ST_OFF && !stopped) |=> st_r != ST_ON)
      else $error("servo on granted to rotating motor");
   a_alarm_recover: assert property (                                    // [RULE6]
      (st_r == ST_ALM && alm_rst && !alarm) |=> st_r == ST_OFF)
      else $error("alarm reset did not leave alarm state");
   a_fwd_blocked: assert property (                                      // [RULE11]
      fwd_ot |=> !(MOTOR_CMD > 0))
      else $error("forward drive into forward limit");
   a_rev_blocked: assert property (                                      // [RULE12]
      rev_ot |=> !(MOTOR_CMD < 0))
      else $error("reverse drive into reverse limit");
   a_base_block: assert property (                                       // [RULE14]
      (ot_stop_r && !cfg_r.zero_hold) |=> !DRIVE_ENABLE)
      else $error("drive not cut after overtravel stop");
   a_brake_ot: assert property (                                         // [RULE15]
      (st_r == ST_ON && (fwd_ot || rev_ot)) |=> BRAKE_CONTROL_OUTPUT)
      else $error("brake engaged during overtravel");
   a_ot_disabled: assert property (                                      // [RULE17]
      (cfg_r.fwd_asg == ASG_OFF) |-> !fwd_ot)
      else $error("disabled forward limit still active");
   a_cmd_ignored: assert property (                                      // [RULE18]
      (st_r != ST_ON) |=> MOTOR_CMD == 0)
      else $error("command passed while de-energized");
   a_dir_map: assert property (                                          // [RULE8]
      (cmd_eff != 0) |=> MOTOR_CW == ($past(cmd_eff[CMD_W-1]) ^ $past(cfg_r.cw_forward)))
      else $error("rotation sense wrong for direction setting");

   c_servo_on:   cover property (st_r == ST_OFF ##1 st_r == ST_ON);
   c_fwd_ot:     cover property (st_r == ST_ON && fwd_ot ##1 ot_stop_r);
   c_alarm_back: cover property (st_r == ST_ALM ##1 st_r == ST_OFF ##[1:20] st_r == ST_ON);
   c_irq:        cover property ($rose(INTERRUPT));
endmodule : servo_enable_and_travel_limit

// ---- dv/host_switch_model.sv ----
`timescale 1ns/10ps
// host controller and limit switch stand-in; pins move just after the edge
module host_switch_model (
   input  wire logic clk,
   input  wire logic want_on,  // host wants the servo on
   input  wire logic fwd_ok,   // forward switch closed
   input  wire logic rev_ok,   // reverse switch closed
   input  wire logic step_req, // encoder step request
   output logic      son_req_n,
   output logic      fwd_lim,
   output logic      rev_lim,
   output logic      enc_step
);
   // servo-on pin follows want_on inverted, one clock later, whatever commands the bench writes
   always_ff @(posedge clk) begin
      son_req_n <= !want_on;
   end
   // switches and encoder step follow the bench
   always_ff @(posedge clk) begin
      fwd_lim  <= fwd_ok;
      rev_lim  <= rev_ok;
      enc_step <= step_req;
   end
endmodule : host_switch_model

// ---- dv/tb.sv ----
`timescale 1ns/10ps
module tb;
   import servo_pkg::*;
   typedef struct packed {logic [31:0] cfg; logic f; logic r; logic [15:0] c; logic [15:0] e;} row_t;
   logic clk, rst, psel, pen, pwr, want, fok, rok, stp, pw, mst, alm, err;
   logic [7:0] pa;
   logic [31:0] pwd, q, prd;
   logic rdy, slv, son_n, fl, rl, es, en, de, zh, bk, cw, pha, phb, irq, a0, b0, ta;
   logic signed [15:0] cmd;
   wire logic [4:0] sig = {irq, zh, de, en, 1'b0}; // observed levels by index
   int cmp_count, miscompares, n;
   row_t rows [6] = '{'{32'h320, 1, 1, 16'h0064, 16'h0064}, '{32'h320, 0, 1, 16'h0064, 16'h0000},
      '{32'h320, 0, 1, 16'hff9c, 16'hff9c}, '{32'h320, 1, 0, 16'hff9c, 16'h0000},
      '{32'h380, 0, 1, 16'h0064, 16'h0064}, '{32'h820, 1, 0, 16'hff9c, 16'hff9c}};
   servo_enable_and_travel_limit u_servo_enable_and_travel_limit (.CLOCK(clk), .RST(rst),
      .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
      .PREADY(rdy), .PSLVERR(slv), .SERVO_ON_REQ_N(son_n), .FORWARD_LIMIT_INPUT(fl),
      .REVERSE_LIMIT_INPUT(rl), .MAIN_POWER_OK(pw), .MOTOR_STOPPED(mst), .DRIVE_ALARM(alm),
      .ENCODER_STEP(es), .MOTOR_ENERGIZE(en), .DRIVE_ENABLE(de), .ZERO_HOLD(zh),
      .BRAKE_CONTROL_OUTPUT(bk), .MOTOR_CMD(cmd), .MOTOR_CW(cw), .DIVIDED_PULSE_PHASE_A(pha),
      .DIVIDED_PULSE_PHASE_B(phb), .INTERRUPT(irq));
   host_switch_model u_host_switch_model (.clk(clk), .want_on(want), .fwd_ok(fok),
      .rev_ok(rok), .step_req(stp), .son_req_n(son_n), .fwd_lim(fl), .rev_lim(rl), .enc_step(es));
   ////////////////////////////////////////////////////////////////////////////////
   // clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // verdict and end of run
   task results;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   // compare seen against expected
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, m, s, e);
      end
   endtask : chk
   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (rdy !== 1'b1 && k < 20);
      q = prd;
      err = slv;
      psel <= 1'b0; pen <= 1'b0;
      if (rdy !== 1'b1) begin
         miscompares++;
         results();
      end
   endtask : apb
   // bounded wait for an output to reach a value, then compare
   task automatic wt(input int i, input logic [15:0] e, input string m);
      int k;
      k = 0;
      while (((i == 0) ? cmd : {15'h0000, sig[i]}) !== e && k < 30) begin
         @(posedge clk);
         k++;
      end
      chk((i == 0) ? cmd : {15'h0000, sig[i]}, e, m);
      if (k == 30) results();
   endtask : wt
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      results();
   end
   initial begin
      rst = 1; psel = 0; pen = 0; pwr = 0; pa = 0; pwd = 0; want = 0; fok = 1; rok = 1;
      stp = 0; pw = 1; mst = 1; alm = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      apb(0, OFS_CONFIG, 0);
      chk(q, 32'h320, "config reset");
      apb(1, OFS_COMMAND, 32'h64);
      repeat (8) @(posedge clk);
      chk(cmd, 0, "command while off");
      chk(en, 0, "off at start");
      mst <= 1'b0; want <= 1'b1;
      repeat (10) @(posedge clk);
      chk(en, 0, "on while rotating");
      mst <= 1'b1;
      wt(1, 1, "servo on");
      $display("test servo on done");
      mst <= 1'b0; // motor turning, so no overtravel stop completes during the rows
      for (int j = 0; j < 6; j++) begin
         apb(1, OFS_CONFIG, rows[j].cfg);
         fok <= rows[j].f; rok <= rows[j].r;
         apb(1, OFS_COMMAND, {16'h0000, rows[j].c});
         wt(0, rows[j].e, "gated command");
         chk(bk, 1, "brake released");
      end
      $display("test limit rows done");
      apb(1, OFS_CONFIG, 32'h320);
      fok <= 1'b0;
      mst <= 1'b1;
      apb(1, OFS_COMMAND, 32'h64);
      wt(2, 0, "base block");
      apb(1, OFS_CONFIG, 32'h2320);
      wt(3, 1, "zero hold");
      chk(de, 1, "drive kept in zero hold");
      fok <= 1'b1;
      rok <= 1'b1;
      $display("test overtravel stop done");
      for (int j = 0; j < 8; j++) begin
         apb(1, OFS_CONFIG, 32'h320 | ((j >> 2) << 12));
         apb(1, OFS_COMMAND, j[1] ? 32'hff9c : 32'h64);
         a0 = pha; b0 = phb;
         ta = (a0 == b0) ? j[1] : !j[1];
         stp <= 1'b1;
         n = 0;
         while ({pha, phb} === {a0, b0} && n < 30) begin
            @(posedge clk);
            n++;
         end
         chk({pha, phb}, {a0 ^ ta, b0 ^ !ta}, "quadrature step");
         stp <= 1'b0;
         repeat (4) @(posedge clk);
      end
      $display("test pulses done");
      apb(1, OFS_INT_MSK, 0);
      apb(0, OFS_INT_ST, 0);
      chk(q[EV_ON], 1, "on event");
      chk(irq, 0, "masked");
      apb(1, OFS_INT_MSK, 32'h1);
      wt(4, 1, "interrupt up");
      apb(1, OFS_INT_ST, 32'h1f);
      wt(4, 0, "interrupt cleared");
      apb(0, 8'h20, 0);
      chk(err, 1, "unmapped error");
      chk(q, 0, "unmapped read");
      $display("test interrupt and bus done");
      want <= 1'b0; pw <= 1'b0;
      apb(1, OFS_CONFIG, 32'h329);
      repeat (8) @(posedge clk);
      chk(en, 0, "no main power");
      pw <= 1'b1;
      wt(1, 1, "permanent on");
      alm <= 1'b1;
      wt(1, 0, "alarm cut");
      alm <= 1'b0;
      repeat (4) @(posedge clk);
      apb(1, OFS_ALM_RST, 32'h1);
      wt(1, 1, "alarm recovery");
      apb(1, OFS_CONFIG, 32'h320);
      wt(1, 0, "pin source off");
      $display("test permanent mode done");
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk(en, 0, "energize cleared by reset");
      rst <= 1'b0;
      apb(0, OFS_CONFIG, 0);
      chk(q, 32'h320, "config after reset");
      $display("test mid-run reset done");
      results();
   end
endmodule : tb
